//--- rtl/tcid_pkg.sv
// Package: register map, field layout and reset values of the capability block
package tcid_pkg;
   // Byte offsets on the APB window
   localparam logic [11:0] OFF_ID0   = 12'h000;  // Capability identification word
   localparam logic [11:0] OFF_CFG   = 12'h004;  // Main trace configuration
   localparam logic [11:0] OFF_EV0   = 12'h008;  // Event control 0, selectors
   localparam logic [11:0] OFF_EV1   = 12'h00c;  // Event control 1, enables
   localparam logic [11:0] OFF_CCC   = 12'h010;  // Cycle count control
   localparam logic [11:0] OFF_BBC   = 12'h014;  // Branch broadcast control
   localparam logic [11:0] OFF_STALL = 12'h018;  // Stall control
   localparam int ADDR_W = 12;                   // Decoded address width
   localparam int DATA_W = 32;                   // APB data width
   // Identification word field positions
   localparam int ID_LSP_LSB   = 1;              // Load/store element field [2:1]
   localparam int ID_DATA_LSB  = 3;              // Data trace field [4:3]
   localparam int ID_BB_BIT    = 5;              // Branch broadcast present
   localparam int ID_CONDITIONAL_TRACE_ENABLE_BIT  = 6;              // Conditional trace present
   localparam int ID_CCI_BIT   = 7;              // Cycle counting present
   localparam int ID_RSV8_BIT  = 8;              // Reserved, reads zero
   localparam int ID_RS_BIT    = 9;              // Return stack present
   localparam int ID_EVC_LSB   = 10;             // Event count field [11:10]
   localparam int ID_RSV0_BIT  = 0;              // Reserved, reads one
   localparam int FLD2_W       = 2;              // Two-bit ID fields
   localparam logic [1:0] FLD_ALL = 2'h3;        // Fully supported encoding
   localparam logic [1:0] FLD_NONE = 2'h0;       // Not supported encoding
   // Main configuration field positions
   localparam int CFG_LSP_LSB  = 1;              // Load/store element enable [2:1]
   localparam int CFG_BB_BIT   = 3;              // Branch broadcast enable
   localparam int CFG_CCI_BIT  = 4;              // Cycle count enable
   localparam int CFG_CONDITIONAL_TRACE_ENABLE_LSB = 8;              // Conditional trace enable [10:8]
   localparam int CFG_CONDITIONAL_TRACE_ENABLE_W   = 3;
   localparam int CFG_RS_BIT   = 12;             // Return stack enable
   localparam int CFG_DA_BIT   = 16;             // Data address enable
   localparam int CFG_DV_BIT   = 17;             // Data value enable
   // Event controls
   localparam int MAX_EVENTS   = 4;              // Largest event count encodable
   localparam int EV_SEL_W     = 8;              // One event selector field
   localparam int EV1_DATA_BIT = 4;              // Data event enable
   // Cycle count and branch broadcast control
   localparam int CCC_THR_W    = 12;             // Cycle count threshold
   localparam int BBC_W        = 9;              // Range select and include bit
   // Stall control field positions
   localparam int STL_LVL_W    = 4;              // Stall level [3:0]
   localparam int STL_PRI_BIT  = 10;             // Instruction priority
   localparam int STL_DSC_LSB  = 11;             // Data discard [12:11]
   localparam int STL_DST_BIT  = 13;             // Data stall
   localparam logic [31:0] RST_WORD = 32'h0000_0000;  // Reset of writable words
endpackage : tcid_pkg

//--- rtl/tcid_regs.sv
// Capability identification word and the configuration registers it gates
`timescale 1ns/10ps
module tcid_regs
   import tcid_pkg::*;
#(
   parameter int unsigned NUM_EVENTS   = 4,     // Supported events, 1 to 4
   parameter bit          HAS_RETURN_STACK_PRESENT = 1'b1,  // Return stack built
   parameter bit          HAS_CCI      = 1'b1,  // Instruction cycle counting built
   parameter bit          HAS_CONDITIONAL_TRACE_ENABLE     = 1'b1,  // Conditional tracing built
   parameter bit          HAS_BB       = 1'b1,  // Branch broadcast built
   parameter bit          HAS_DATA     = 1'b1,  // Data address and value tracing built
   parameter bit          HAS_LSP0     = 1'b1   // Load/store P0 elements built
)
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_W-1:0]     paddr,
   input  wire logic [DATA_W-1:0]     pwdata,
   output logic      [DATA_W-1:0]     prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic      [DATA_W-1:0]     main_trace_config,
   output logic      [DATA_W-1:0]     event_control_0,
   output logic      [DATA_W-1:0]     event_control_1,
   output logic      [DATA_W-1:0]     cycle_count_control,
   output logic      [DATA_W-1:0]     branch_broadcast_control,
   output logic      [DATA_W-1:0]     stall_control
);

   // Stored words; absent fields never hold a one
   logic [DATA_W-1:0] cfg_q;          // Main trace configuration
   logic [DATA_W-1:0] ev0_q;          // Event selectors
   logic [DATA_W-1:0] ev1_q;          // Per-event and data enables
   logic [DATA_W-1:0] ccc_q;          // Cycle count threshold
   logic [DATA_W-1:0] bbc_q;          // Branch broadcast ranges
   logic [DATA_W-1:0] stl_q;          // Stall control
   logic [DATA_W-1:0] prdata_q;       // Read data, captured in setup phase

   // Fixed words and write masks, all derived from build parameters
   logic [DATA_W-1:0] id_word;        // Identification value
   logic [DATA_W-1:0] cfg_mask;       // Writable bits of main configuration
   logic [DATA_W-1:0] ev0_mask;       // Writable selector bits
   logic [DATA_W-1:0] ev1_mask;       // Writable enable bits
   logic [DATA_W-1:0] ccc_mask;       // Writable threshold bits
   logic [DATA_W-1:0] bbc_mask;       // Writable branch broadcast bits
   logic [DATA_W-1:0] stl_mask;       // Writable stall bits
   logic [1:0]        evc_code;       // Events minus one
   logic [MAX_EVENTS-1:0] insn_en_mask;  // One instruction enable per built event

   // Event count code; truncation to two bits is intended
   assign evc_code = 2'(NUM_EVENTS - 1);

   // Identification word assembly
   always_comb
   begin
      id_word                            = '0;
      id_word[ID_EVC_LSB +: FLD2_W]      = evc_code;
      id_word[ID_RS_BIT]                 = HAS_RETURN_STACK_PRESENT;
      id_word[ID_RSV8_BIT]               = 1'b0;
      id_word[ID_CCI_BIT]                = HAS_CCI;
      id_word[ID_CONDITIONAL_TRACE_ENABLE_BIT]               = HAS_CONDITIONAL_TRACE_ENABLE;
      id_word[ID_BB_BIT]                 = HAS_BB;
      // Only the two legal codes are ever produced
      id_word[ID_DATA_LSB +: FLD2_W]     = HAS_DATA ? FLD_ALL : FLD_NONE;
      id_word[ID_LSP_LSB +: FLD2_W]      = HAS_LSP0 ? FLD_ALL : FLD_NONE;
      id_word[ID_RSV0_BIT]               = 1'b1;
   end

   // Main configuration: a bit is writable only if its feature exists
   always_comb
   begin
      cfg_mask                              = '0;
      cfg_mask[CFG_RS_BIT]                  = HAS_RETURN_STACK_PRESENT;
      cfg_mask[CFG_CCI_BIT]                 = HAS_CCI;
      cfg_mask[CFG_CONDITIONAL_TRACE_ENABLE_LSB +: CFG_CONDITIONAL_TRACE_ENABLE_W]  = {CFG_CONDITIONAL_TRACE_ENABLE_W{HAS_CONDITIONAL_TRACE_ENABLE}};
      cfg_mask[CFG_BB_BIT]                  = HAS_BB;
      cfg_mask[CFG_DA_BIT]                  = HAS_DATA;
      cfg_mask[CFG_DV_BIT]                  = HAS_DATA;
      cfg_mask[CFG_LSP_LSB +: FLD2_W]       = {FLD2_W{HAS_LSP0}};
   end

   // One selector and one instruction enable per supported event
   genvar gi;
   generate
      for (gi = 0; gi < MAX_EVENTS; gi++)
      begin : g_event
         assign ev0_mask[gi*EV_SEL_W +: EV_SEL_W] =
            {EV_SEL_W{gi < NUM_EVENTS}};
         assign insn_en_mask[gi] = (gi < NUM_EVENTS);
      end
   endgenerate

   // Event control 1 mask in one process; data enable only with data tracing
   always_comb
   begin
      ev1_mask                       = '0;
      ev1_mask[MAX_EVENTS-1:0]       = insn_en_mask;
      ev1_mask[EV1_DATA_BIT]         = HAS_DATA;
   end

   // Cycle count and branch broadcast controls exist only when built
   assign ccc_mask = HAS_CCI ? DATA_W'({CCC_THR_W{1'b1}}) : '0;
   assign bbc_mask = HAS_BB  ? DATA_W'({BBC_W{1'b1}})     : '0;

   // Stall control: level always, priority and data fields only with data tracing
   always_comb
   begin
      stl_mask                             = '0;
      stl_mask[STL_LVL_W-1:0]              = '1;
      stl_mask[STL_PRI_BIT]                = HAS_DATA;
      stl_mask[STL_DSC_LSB +: FLD2_W]      = {FLD2_W{HAS_DATA}};
      stl_mask[STL_DST_BIT]                = HAS_DATA;
   end

   // Address decode; absent controls behave as unmapped
   logic sel_id;                      // Identification word
   logic sel_cfg;                     // Main configuration
   logic sel_ev0;                     // Event control 0
   logic sel_ev1;                     // Event control 1
   logic sel_ccc;                     // Cycle count control
   logic sel_bbc;                     // Branch broadcast control
   logic sel_stl;                     // Stall control
   logic hit;                         // Any mapped register
   logic setup_rd;                    // Read setup phase
   logic access;                      // Access phase
   logic wr_en;                       // Write takes effect this edge

   assign sel_id   = (paddr == OFF_ID0);
   assign sel_cfg  = (paddr == OFF_CFG);
   assign sel_ev0  = (paddr == OFF_EV0);
   assign sel_ev1  = (paddr == OFF_EV1);
   assign sel_ccc  = (paddr == OFF_CCC) && HAS_CCI;
   assign sel_bbc  = (paddr == OFF_BBC) && HAS_BB;
   assign sel_stl  = (paddr == OFF_STALL);
   assign hit      = sel_id | sel_cfg | sel_ev0 | sel_ev1 | sel_ccc | sel_bbc | sel_stl;
   assign setup_rd = psel && !penable && !pwrite;
   assign access   = psel && penable;
   assign wr_en    = access && pwrite && hit;

   // Zero-wait slave; the error flag marks unmapped addresses only
   assign pready  = 1'b1;
   assign pslverr = access && !hit;

   // Read selection, captured at the setup edge so prdata is a flop
   logic [DATA_W-1:0] rd_mux;         // Selected read value
   assign rd_mux = ({DATA_W{sel_id}}  & id_word)
                 | ({DATA_W{sel_cfg}} & cfg_q)
                 | ({DATA_W{sel_ev0}} & ev0_q)
                 | ({DATA_W{sel_ev1}} & ev1_q)
                 | ({DATA_W{sel_ccc}} & ccc_q)
                 | ({DATA_W{sel_bbc}} & bbc_q)
                 | ({DATA_W{sel_stl}} & stl_q);

   // Read data register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= RST_WORD;
      else if (setup_rd)
         prdata_q <= rd_mux;
   end

   // Writable registers; the identification word has no storage at all
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_q <= RST_WORD;
         ev0_q <= RST_WORD;
         ev1_q <= RST_WORD;
         ccc_q <= RST_WORD;
         bbc_q <= RST_WORD;
         stl_q <= RST_WORD;
      end
      else if (wr_en)
      begin
         // Masks drop writes to fields the build lacks
         if (sel_cfg) cfg_q <= pwdata & cfg_mask;
         if (sel_ev0) ev0_q <= pwdata & ev0_mask;
         if (sel_ev1) ev1_q <= pwdata & ev1_mask;
         if (sel_ccc) ccc_q <= pwdata & ccc_mask;
         if (sel_bbc) bbc_q <= pwdata & bbc_mask;
         if (sel_stl) stl_q <= pwdata & stl_mask;
      end
   end

   // Outputs to the trace logic
   assign prdata                   = prdata_q;
   assign main_trace_config        = cfg_q;
   assign event_control_0          = ev0_q;
   assign event_control_1          = ev1_q;
   assign cycle_count_control      = ccc_q;
   assign branch_broadcast_control = bbc_q;
   assign stall_control            = stl_q;

   // Checks on the design's own outputs
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Read of the identification word, setup then access
   sequence s_id_read;
      setup_rd && sel_id ##1 access;
   endsequence

   // Write to the identification word followed by a read of it
   sequence s_id_write_then_read;
      access && pwrite && sel_id ##1 setup_rd && sel_id;
   endsequence

   // Read of an address that nothing decodes
   sequence s_miss_read;
      setup_rd && !hit ##1 access;
   endsequence

   a_id_event_count: assert property (
      s_id_read |-> prdata[ID_EVC_LSB +: FLD2_W] == 2'(NUM_EVENTS - 1))
      else $error("event count field wrong");

   a_ev0_unused_sel: assert property (
      wr_en && sel_ev0 && pwdata == '1 |=>
      $countones(ev0_q) == EV_SEL_W * NUM_EVENTS)
      else $error("selector fields do not match event count");

   a_ev1_insn_width: assert property (
      wr_en && sel_ev1 && pwdata == '1 |=>
      $countones(ev1_q[MAX_EVENTS-1:0]) == NUM_EVENTS)
      else $error("instruction enable width wrong");

   a_cfg_rs_gated: assert property (
      s_id_read ##1 cfg_q[CFG_RS_BIT] |-> $past(prdata[ID_RS_BIT], 1) == 1'b1)
      else $error("return stack enable set without return stack");

   a_ccc_presence: assert property (
      access && paddr == OFF_CCC |-> pslverr == !HAS_CCI &&
      (ccc_q == '0 || id_word[ID_CCI_BIT]))
      else $error("cycle count control presence wrong");

   a_cfg_conditional_trace_enable_gated: assert property (
      cfg_q[CFG_CONDITIONAL_TRACE_ENABLE_LSB +: CFG_CONDITIONAL_TRACE_ENABLE_W] != '0 |-> id_word[ID_CONDITIONAL_TRACE_ENABLE_BIT])
      else $error("conditional enable set without support");

   a_bbc_presence: assert property (
      access && paddr == OFF_BBC |-> pslverr == !HAS_BB)
      else $error("branch broadcast control presence wrong");

   a_id_data_code: assert property (
      s_id_read |-> prdata[ID_DATA_LSB +: FLD2_W] inside {FLD_NONE, FLD_ALL})
      else $error("reserved data trace code");

   a_data_fields_gated: assert property (
      (ev1_q[EV1_DATA_BIT] || stl_q[STL_DST_BIT] || cfg_q[CFG_DV_BIT]) |->
      id_word[ID_DATA_LSB +: FLD2_W] == FLD_ALL)
      else $error("data field set without data tracing");

   a_id_lsp_code: assert property (
      s_id_read |-> prdata[ID_LSP_LSB +: FLD2_W] == {FLD2_W{HAS_LSP0}})
      else $error("load store element code wrong");

   a_id_reserved_bits: assert property (
      s_id_read |-> !prdata[ID_RSV8_BIT] && prdata[ID_RSV0_BIT])
      else $error("reserved identification bits wrong");

   a_id_read_only: assert property (
      s_id_write_then_read |=> prdata == $past(id_word, 2) && !pslverr)
      else $error("identification word changed by a write");

   // Feature flags on a read of the identification word
   a_id_rs_flag: assert property (
      s_id_read |-> prdata[ID_RS_BIT] == HAS_RETURN_STACK_PRESENT)
      else $error("return stack flag wrong");

   a_id_cci_flag: assert property (
      s_id_read |-> prdata[ID_CCI_BIT] == HAS_CCI)
      else $error("cycle counting flag wrong");

   a_id_conditional_trace_enable_flag: assert property (
      s_id_read |-> prdata[ID_CONDITIONAL_TRACE_ENABLE_BIT] == HAS_CONDITIONAL_TRACE_ENABLE)
      else $error("conditional trace flag wrong");

   a_id_bb_flag: assert property (
      s_id_read |-> prdata[ID_BB_BIT] == HAS_BB)
      else $error("branch broadcast flag wrong");

   // Upper part holds fields this block does not build
   a_id_upper_zero: assert property (
      s_id_read |-> prdata[DATA_W-1:ID_EVC_LSB+FLD2_W] == '0)
      else $error("identification upper bits not zero");

   // Stored words never hold a bit of an absent feature
   a_cfg_built_only: assert property (
      (cfg_q & ~cfg_mask) == '0)
      else $error("configuration bit of absent feature set");

   a_ev0_built_only: assert property (
      (ev0_q & ~ev0_mask) == '0)
      else $error("selector of absent event set");

   a_ev1_built_only: assert property (
      (ev1_q & ~ev1_mask) == '0)
      else $error("enable of absent event set");

   a_ccc_built_only: assert property (
      (ccc_q & ~ccc_mask) == '0)
      else $error("cycle count control set without counting");

   a_bbc_built_only: assert property (
      (bbc_q & ~bbc_mask) == '0)
      else $error("branch broadcast control set without support");

   a_stl_built_only: assert property (
      (stl_q & ~stl_mask) == '0)
      else $error("stall data field set without data tracing");

   // A write lands, masked, on the edge that ends its access phase
   a_cfg_write_lands: assert property (
      wr_en && sel_cfg |=> cfg_q == ($past(pwdata) & cfg_mask))
      else $error("configuration write lost");

   // Unmapped reads answer zero with an error
   a_miss_read_zero: assert property (
      s_miss_read |-> prdata == '0 && pslverr)
      else $error("unmapped read not refused");

   a_err_in_access: assert property (
      pslverr |-> access)
      else $error("error flag outside access phase");

endmodule : tcid_regs

//--- tb/tcid_regs_tb.sv
// Self-checking bench: capability word and gated configuration registers over APB
`timescale 1ns/10ps
module tcid_regs_tb;
   import tcid_pkg::*;
   logic              pclk    = 1'b0;       // 40 MHz bus clock
   logic              presetn = 1'b0;       // Active low reset
   logic              psel_a  = 1'b0;       // Select, full-feature instance
   logic              psel_b  = 1'b0;       // Select, reduced instance
   logic              penable = 1'b0;       // Shared access phase
   logic              pwrite  = 1'b0;       // Shared direction
   logic [11:0]       paddr   = 12'h000;    // Shared address
   logic [31:0]       pwdata  = 32'h0000_0000;  // Shared write data
   logic [31:0]       prd_a, prd_b;         // Read data per instance
   logic              rdy_a, rdy_b, err_a, err_b;  // Responses per instance
   logic [31:0]       cfg_a, ev0_a, ev1_a, ccc_a, bbc_a, stl_a;  // Outputs, full
   logic [31:0]       cfg_b, ev0_b, ev1_b, ccc_b, bbc_b, stl_b;  // Outputs, reduced
   logic              cur     = 1'b0;       // Instance addressed by the task
   int                n_mismatch = 0;       // Mismatch counter
   int                checks  = 0;          // Comparison counter
   int                cyc     = 0;          // Timeout counter
   logic [31:0]       rv;                   // Last read value
   logic              ev;                   // Last error response
   // Register offsets, expected all-ones readback, and unmapped flags
   logic [11:0] offs [7] = '{OFF_ID0, OFF_CFG, OFF_EV0, OFF_EV1, OFF_CCC, OFF_BBC, OFF_STALL};
   logic [31:0] m_a [7] = '{32'h0000_0eff, 32'h0003_171e, 32'hffff_ffff, 32'h0000_001f,
                            32'h0000_0fff, 32'h0000_01ff, 32'h0000_3c0f};
   logic [31:0] m_b [7] = '{32'h0000_0447, 32'h0000_0706, 32'h0000_ffff, 32'h0000_0003,
                            32'h0000_0000, 32'h0000_0000, 32'h0000_000f};
   logic        u_b [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   // Clock generation
   always #12.5 pclk = ~pclk;
   // Full-feature build, four events
   tcid_regs tcid_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel_a), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prd_a), .pready(rdy_a),
      .pslverr(err_a), .main_trace_config(cfg_a), .event_control_0(ev0_a),
      .event_control_1(ev1_a), .cycle_count_control(ccc_a),
      .branch_broadcast_control(bbc_a), .stall_control(stl_a));
   // Reduced build: two events, no return stack, cycle count, branch broadcast or data
   tcid_regs #(.NUM_EVENTS(2), .HAS_RETURN_STACK_PRESENT(1'b0), .HAS_CCI(1'b0),
      .HAS_BB(1'b0), .HAS_DATA(1'b0)) tcid_regs_b_i (.pclk(pclk),
      .presetn(presetn), .psel(psel_b), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prd_b), .pready(rdy_b), .pslverr(err_b),
      .main_trace_config(cfg_b), .event_control_0(ev0_b), .event_control_1(ev1_b),
      .cycle_count_control(ccc_b), .branch_broadcast_control(bbc_b), .stall_control(stl_b));
   // Compare and report
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One APB transfer; keep holds psel for a back-to-back setup on the same instance
   task automatic apb(input logic inst, input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic keep);
      int waits;
      cur = inst;
      if (inst) psel_b <= 1'b1; else psel_a <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      waits = 0;
      // Wait for pready under a bound; never assume the latency
      do
      begin
         @(posedge pclk);
         waits++;
      end
      while ((cur ? rdy_b : rdy_a) !== 1'b1 && waits < 64);
      if (waits >= 64) chk("pready", 32'h1, 32'h0);
      rv = cur ? prd_b : prd_a;
      ev = cur ? err_b : err_a;
      penable <= 1'b0;
      if (!keep)
      begin
         psel_a <= 1'b0;
         psel_b <= 1'b0;
         @(posedge pclk);
      end
   endtask : apb
   // Verdict
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   // Hang guard
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // Main sequence
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values, identification word, unmapped decode
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b0, 1'b0, offs[i], 32'h0, 1'b0);
         chk("rst_a", (i == 0) ? m_a[0] : 32'h0, rv);
         chk("err_a", 32'h0, {31'h0, ev});
         apb(1'b1, 1'b0, offs[i], 32'h0, 1'b0);
         chk("rst_b", (i == 0) ? m_b[0] : 32'h0, rv);
         chk("err_b", {31'h0, u_b[i]}, {31'h0, ev});
      end
      // All-ones write then back-to-back readback: only built fields stick
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b0, 1'b1, offs[i], 32'hffff_ffff, 1'b1);
         apb(1'b0, 1'b0, offs[i], 32'h0, 1'b0);
         chk("ones_a", m_a[i], rv);
         apb(1'b1, 1'b1, offs[i], 32'hffff_ffff, 1'b1);
         chk("werr_b", {31'h0, u_b[i]}, {31'h0, ev});
         apb(1'b1, 1'b0, offs[i], 32'h0, 1'b0);
         chk("ones_b", m_b[i], rv);
      end
      // Register outputs follow the stored values
      chk("cfg_a", m_a[1], cfg_a);
      chk("ev0_b", m_b[2], ev0_b);
      chk("ev1_a", m_a[3], ev1_a);
      chk("ev1_b", m_b[3], ev1_b);
      chk("stl_b", m_b[6], stl_b);
      chk("ccc_a", m_a[4], ccc_a);
      chk("bbc_a", m_a[5], bbc_a);
      chk("ev0_a", m_a[2], ev0_a);
      chk("stl_a", m_a[6], stl_a);
      chk("cfg_b", m_b[1], cfg_b);
      chk("ccc_b", m_b[4], ccc_b);
      chk("bbc_b", m_b[5], bbc_b);
      // Clearing write to the identification word leaves it fixed
      apb(1'b0, 1'b1, OFF_ID0, 32'h0, 1'b1);
      apb(1'b0, 1'b0, OFF_ID0, 32'h0, 1'b0);
      chk("id_a", m_a[0], rv);
      // Unmapped address: error response and zero data
      apb(1'b0, 1'b0, 12'h01c, 32'h0, 1'b0);
      chk("unm_d", 32'h0, rv);
      chk("unm_e", 32'h1, {31'h0, ev});
      // Second reset in mid-run clears writable registers, not the ID word
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("cfg_rst", 32'h0, cfg_a);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 1'b0, OFF_CFG, 32'h0, 1'b0);
      chk("cfg_rd", 32'h0, rv);
      apb(1'b1, 1'b0, OFF_ID0, 32'h0, 1'b0);
      chk("id_b", m_b[0], rv);
      tally_and_finish();
   end
endmodule : tcid_regs_tb
